/* File: rtl/flash_device.sv */
/*
 Flash device command logic: security area erase and program, software
 reset pair, parameter read, page program and status read.
 Assumes the link pins are asynchronous to SYS_CLK and a main array
 outside that takes the byte write port.
*/
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "spi_flash_regs.svh"

// Function
// - three 256-byte areas selected by address
// - area erase 44H needs write enable
// - erase runs only if select rises after byte
// - erase cycle with progress flag set
// - write enable cleared before cycle ends
// - global lock ignores area erase
// - area program 42H, address, data, enable
// - area program runs timed with progress flag
// - any area lock ignores area program
// - reset aborts work, clears volatile state
// - reset needs 66h then 99h
// - other command cancels armed reset
// - reset interval refuses every command
// - host checks busy before reset pair
// - 5AH read returns FFH fill after dummy byte
// - page program 02H with address and data
// - unaligned bytes wrap within the page
// - over 256 bytes keeps the last 256
// - fewer bytes leave rest of page
// - select must rise on byte boundary
// - page program timed with progress flag
// - protected pages are not programmed; any nonzero BLOCK_PROT refuses every page program
module flash_device #(
	parameter int unsigned ERASE_CYCLES = `ERASE_TIME_US * `CLK_MHZ,
	parameter int unsigned PROG_CYCLES = `PROG_TIME_US * `CLK_MHZ
) (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	spi_link_if.dev LINK,
	input wire logic SEC_LOCK,
	input wire logic [2:0] AREA_LOCK,
	input wire logic [4:0] BLOCK_PROT,
	input wire logic [9:0] SEC_RD_ADDR,
	output logic [7:0] SEC_RD_DATA,
	output logic WRITE_IN_PROGRESS_FLAG,
	output logic WRITE_ENABLE_LATCH,
	output logic RESET_BUSY,
	output logic MEM_WR_EN,
	output logic [23:0] MEM_WR_ADDR,
	output logic [7:0] MEM_WR_DATA
);
	// area number 1..3, zero when the address is no area
	function automatic logic [1:0] sec_area(input logic [23:0] a);
		logic [1:0] r;
		r = 2'h0;
		if (a[23:16] == 8'h00 && a[11:8] == 4'h0 &&
				a[15:12] >= `SEC_AREA_FIRST && a[15:12] <= `SEC_AREA_LAST) begin
			r = a[13:12];
		end
		return r;
	endfunction : sec_area

	logic [1:0] cs_sync_q, sclk_sync_q, si_sync_q;
	logic cs_prev_q, sclk_prev_q;
	logic [2:0] bit_in_q;
	logic [15:0] byte_num_q;
	logic [7:0] shift_q, op_q, ptr_q;
	logic [23:0] addr_q;
	logic [15:0] job_q;
	logic [255:0] valid_q;
	logic [7:0] page_buf [0:255];
	logic [7:0] sec_mem [0:767];
	logic so_q, wel_q, wip_q, rst_busy_q, armed_q;
	logic [31:0] timer_q;
	logic [9:0] idx_q, idx_lim;
	logic mem_en_q;
	logic [23:0] mem_addr_q;
	logic [7:0] mem_data_q, sec_rd_q, in_byte, tx_byte;
	spi_flash_pkg::dev_state_type st_q, st_d;
	logic sel, frame_start, frame_end, clk_rise, clk_fall, byte_done;
	logic idle, exact1, exact_data, data_wr, walk_done;
	logic start_erase, start_sprog, start_mprog, set_wel, do_reset;

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			cs_sync_q <= 2'h3;
			sclk_sync_q <= 2'h0;
			si_sync_q <= 2'h0;
			cs_prev_q <= 1'b1;
			sclk_prev_q <= 1'b0;
		end else begin
			cs_sync_q <= {cs_sync_q[0], LINK.cs_n};
			sclk_sync_q <= {sclk_sync_q[0], LINK.sclk};
			si_sync_q <= {si_sync_q[0], LINK.si};
			cs_prev_q <= cs_sync_q[1];
			sclk_prev_q <= sclk_sync_q[1];
		end
	end

	assign sel = ~cs_sync_q[1];
	assign frame_start = sel & cs_prev_q;
	assign frame_end = cs_sync_q[1] & ~cs_prev_q;
	assign clk_rise = sel & sclk_sync_q[1] & ~sclk_prev_q;
	assign clk_fall = sel & ~sclk_sync_q[1] & sclk_prev_q;
	assign byte_done = clk_rise & (bit_in_q == 3'h7);
	assign in_byte = {shift_q[6:0], si_sync_q[1]};
	assign idle = (st_q == spi_flash_pkg::DEV_IDLE);

	// bit and byte counting within a frame
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			bit_in_q <= 3'h0;
			byte_num_q <= 16'h0000;
			shift_q <= 8'h00;
		end else if (frame_start) begin
			bit_in_q <= 3'h0;
			byte_num_q <= 16'h0000;
		end else if (clk_rise) begin
			bit_in_q <= bit_in_q + 3'h1;
			shift_q <= in_byte;
			if (bit_in_q == 3'h7 && byte_num_q != 16'hFFFF) begin
				byte_num_q <= byte_num_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			op_q <= 8'h00;
			addr_q <= 24'h000000;
			ptr_q <= 8'h00;
		end else if (byte_done) begin
			if (byte_num_q == 16'h0000) begin
				op_q <= in_byte;
			end else if (byte_num_q <= 16'h0003) begin
				addr_q <= {addr_q[15:0], in_byte};
			end
			if (byte_num_q == 16'h0003) begin
				ptr_q <= in_byte;
			end else if (byte_num_q >= 16'h0004) begin
				ptr_q <= ptr_q + 8'h01;
			end
		end
	end

	// data bytes land at their page offset; later bytes overwrite
	assign data_wr = byte_done & idle & (byte_num_q >= 16'h0004) &
		(op_q == `OP_PAGE_PROGRAM || op_q == `OP_SEC_PROGRAM);

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			valid_q <= '0;
		end else if (frame_start && idle) begin
			valid_q <= '0;
		end else if (data_wr) begin
			valid_q[ptr_q] <= 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (data_wr) begin
			page_buf[ptr_q] <= in_byte;
		end
	end

	// serial answer for status and parameter reads
	always_comb begin
		tx_byte = 8'h00;
		if (op_q == `OP_READ_STATUS) begin
			tx_byte[`ST_WIP_BIT] = wip_q;
			tx_byte[`ST_WEL_BIT] = wel_q;
		end else if (byte_num_q >= 16'h0005) begin
			tx_byte = `PARAM_FILL_BYTE;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			so_q <= 1'b0;
		end else if (frame_start || !sel) begin
			so_q <= 1'b0; // line released low between frames
		end else if (clk_fall && byte_num_q != 16'h0000 && !rst_busy_q &&
				(op_q == `OP_READ_STATUS || op_q == `OP_READ_PARAMS)) begin
			so_q <= tx_byte[~bit_in_q];
		end
	end
	assign LINK.so = so_q;

	// frame end decode
	assign exact1 = (bit_in_q == 3'h0) && (byte_num_q == 16'h0001);
	assign exact_data = (bit_in_q == 3'h0) && (byte_num_q >= 16'h0005);
	assign start_erase = frame_end & idle & exact1 & wel_q & ~SEC_LOCK &
		(op_q == `OP_SEC_ERASE);
	assign start_sprog = frame_end & idle & exact_data & wel_q &
		~(|AREA_LOCK) & (sec_area(addr_q) != 2'h0) &
		(op_q == `OP_SEC_PROGRAM);
	assign start_mprog = frame_end & idle & exact_data & wel_q &
		(BLOCK_PROT == 5'h00) & (op_q == `OP_PAGE_PROGRAM);
	assign set_wel = frame_end & idle & exact1 & (op_q == `OP_WRITE_ENABLE);
	assign do_reset = frame_end & ~rst_busy_q & exact1 & armed_q &
		(op_q == `OP_RESET);

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			armed_q <= 1'b0;
		end else if (frame_end && !rst_busy_q && byte_num_q != 16'h0000) begin
			armed_q <= exact1 && (op_q == `OP_RESET_ENABLE);
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			wel_q <= 1'b0;
		end else if (do_reset || start_erase || start_sprog || start_mprog) begin
			wel_q <= 1'b0;
		end else if (set_wel) begin
			wel_q <= 1'b1;
		end
	end

	assign idx_lim = (st_q == spi_flash_pkg::DEV_SEC_ERASE) ?
		`SEC_TOTAL_BYTES : `SEC_AREA_BYTES;
	assign walk_done = (idx_q == idx_lim);

	always_comb begin
		st_d = st_q;
		case (st_q)
			spi_flash_pkg::DEV_IDLE: begin
				if (start_erase) st_d = spi_flash_pkg::DEV_SEC_ERASE;
				else if (start_sprog) st_d = spi_flash_pkg::DEV_SEC_PROG;
				else if (start_mprog) st_d = spi_flash_pkg::DEV_MAIN_PROG;
			end
			spi_flash_pkg::DEV_RESETTING: begin
				if (timer_q == 32'h0) st_d = spi_flash_pkg::DEV_IDLE;
			end
			default: begin
				if (walk_done && timer_q == 32'h0) st_d = spi_flash_pkg::DEV_IDLE;
			end
		endcase
		if (do_reset) st_d = spi_flash_pkg::DEV_RESETTING;
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_q <= spi_flash_pkg::DEV_IDLE;
			wip_q <= 1'b0;
			rst_busy_q <= 1'b0;
		end else begin
			st_q <= st_d;
			wip_q <= (st_d != spi_flash_pkg::DEV_IDLE) &&
				(st_d != spi_flash_pkg::DEV_RESETTING);
			rst_busy_q <= (st_d == spi_flash_pkg::DEV_RESETTING);
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			timer_q <= 32'h0;
			idx_q <= 10'h000;
			job_q <= 16'h0000;
		end else if (do_reset) begin
			timer_q <= 32'(`RESET_CYCLES - 1);
			idx_q <= 10'h000;
		end else if (idle) begin
			idx_q <= 10'h000;
			job_q <= addr_q[23:8];
			if (start_erase) timer_q <= 32'(ERASE_CYCLES - 1);
			else if (start_sprog || start_mprog) timer_q <= 32'(PROG_CYCLES - 1);
		end else begin
			if (timer_q != 32'h0) timer_q <= timer_q - 32'h1;
			if (!walk_done && st_q != spi_flash_pkg::DEV_RESETTING) begin
				idx_q <= idx_q + 10'h001;
			end
		end
	end

	// security array walk; erase sets every byte, program changes only written bytes
	always_ff @(posedge SYS_CLK) begin
		if (!walk_done && st_q == spi_flash_pkg::DEV_SEC_ERASE) begin
			sec_mem[idx_q] <= `ERASED_BYTE;
		end else if (!walk_done && st_q == spi_flash_pkg::DEV_SEC_PROG &&
				valid_q[idx_q[7:0]]) begin
			sec_mem[{sec_area({job_q, 8'h00}) - 2'h1, idx_q[7:0]}] <=
				sec_mem[{sec_area({job_q, 8'h00}) - 2'h1, idx_q[7:0]}] &
				page_buf[idx_q[7:0]];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			mem_en_q <= 1'b0;
			mem_addr_q <= 24'h000000;
			mem_data_q <= 8'h00;
		end else begin
			mem_en_q <= !walk_done && st_q == spi_flash_pkg::DEV_MAIN_PROG &&
				valid_q[idx_q[7:0]];
			mem_addr_q <= {job_q, idx_q[7:0]};
			mem_data_q <= page_buf[idx_q[7:0]];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			sec_rd_q <= 8'h00;
		end else begin
			sec_rd_q <= (SEC_RD_ADDR < `SEC_TOTAL_BYTES) ?
				sec_mem[SEC_RD_ADDR] : 8'h00;
		end
	end

	assign SEC_RD_DATA = sec_rd_q;
	assign WRITE_IN_PROGRESS_FLAG = wip_q;
	assign WRITE_ENABLE_LATCH = wel_q;
	assign RESET_BUSY = rst_busy_q;
	assign MEM_WR_EN = mem_en_q;
	assign MEM_WR_ADDR = mem_addr_q;
	assign MEM_WR_DATA = mem_data_q;
endmodule : flash_device

/* File: rtl/spi_flash_regs.svh */
/*
 Constants of the serial flash link: opcodes, field values, timing
 and the host controller register offsets.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SPI_FLASH_REGS_SVH
`define SPI_FLASH_REGS_SVH

`define OP_WRITE_ENABLE 8'h06
`define OP_READ_STATUS 8'h05
`define OP_SEC_ERASE 8'h44
`define OP_SEC_PROGRAM 8'h42
`define OP_RESET_ENABLE 8'h66
`define OP_RESET 8'h99
`define OP_READ_PARAMS 8'h5A
`define OP_PAGE_PROGRAM 8'h02

`define SEC_AREA_FIRST 4'h1
`define SEC_AREA_LAST 4'h3
`define SEC_AREA_BYTES 10'h100
`define SEC_TOTAL_BYTES 10'h300

`define ST_WIP_BIT 0
`define ST_WEL_BIT 1
`define PARAM_FILL_BYTE 8'hFF
`define ERASED_BYTE 8'hFF

`define CLK_MHZ 50
`define ERASE_TIME_US 1000
`define PROG_TIME_US 100
`define RESET_TIME_US 30
`define RESET_CYCLES (`RESET_TIME_US * `CLK_MHZ)
`define LINK_HALF_CYCLES 4'h4

`define HREG_CMD 4'h0
`define HREG_ADDR 4'h1
`define HREG_LEN 4'h2
`define HREG_DATA 4'h3
`define HREG_STAT 4'h4
`define HSTAT_BUSY_BIT 8

`endif

/* File: rtl/spi_flash_pkg.sv */
/*
 Types shared by both ends of the serial flash link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package spi_flash_pkg;
	typedef enum logic [2:0] {
		DEV_IDLE, DEV_SEC_ERASE, DEV_SEC_PROG, DEV_MAIN_PROG, DEV_RESETTING
	} dev_state_type;
	typedef enum logic [2:0] {
		HOST_IDLE, HOST_LOW, HOST_HIGH, HOST_TAIL, HOST_REST
	} host_state_type;
endpackage : spi_flash_pkg

/* File: rtl/spi_link_if.sv */
/*
 Serial link between the flash controller and the flash device.
 Assumes both ends run on their own system clock and sample the link.
*/
`timescale 1ns/100ps
interface spi_link_if;
	logic cs_n;
	logic sclk;
	logic si;
	logic so;
	modport dev (input cs_n, input sclk, input si, output so);
	modport host (output cs_n, output sclk, output si, input so);
endinterface : spi_link_if

/* File: rtl/flash_host.sv */
/*
 Host flash controller: software fills registers, the controller
 sends one framed command on the serial link and keeps the last byte.
 Assumes a one-cycle register master on SYS_CLK.
*/
`timescale 1ns/100ps
`include "spi_flash_regs.svh"

module flash_host (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	spi_link_if.host LINK,
	input wire logic [3:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA
);
	// opcode, address and dummy bits ahead of the data phase
	function automatic logic [15:0] hdr_bits(input logic [7:0] op);
		logic [15:0] n;
		n = 16'd8;
		if (op == `OP_SEC_PROGRAM || op == `OP_PAGE_PROGRAM ||
				op == `OP_READ_PARAMS) n = 16'd32;
		if (op == `OP_READ_PARAMS) n = 16'd40;
		return n;
	endfunction : hdr_bits

	logic [7:0] op_q, wptr_q, rx_q;
	logic [23:0] addr_q;
	logic [8:0] len_q;
	logic [7:0] data_buf [0:255];
	logic [15:0] bit_q, total_q, j;
	logic [3:0] div_q;
	logic cs_q, sclk_q, si_q, cur_bit, is_write, half_done;
	logic [1:0] so_sync_q;
	logic [31:0] rdata_q;
	spi_flash_pkg::host_state_type st_q;
	logic start;

	assign start = REG_WR && REG_ADDR == `HREG_CMD &&
		st_q == spi_flash_pkg::HOST_IDLE;
	assign is_write = (op_q == `OP_SEC_PROGRAM) ||
		(op_q == `OP_PAGE_PROGRAM);
	assign half_done = (div_q == `LINK_HALF_CYCLES - 4'h1);
	assign j = bit_q - hdr_bits(op_q);

	always_comb begin
		cur_bit = 1'b0;
		if (bit_q < 16'd8) begin
			cur_bit = op_q[~bit_q[2:0]];
		end else if (bit_q < 16'd32 && hdr_bits(op_q) != 16'd8) begin
			cur_bit = addr_q[5'(16'd31 - bit_q)];
		end else if (bit_q >= hdr_bits(op_q) && is_write) begin
			cur_bit = data_buf[j[10:3]][~j[2:0]];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			op_q <= 8'h00;
			addr_q <= 24'h000000;
			len_q <= 9'h000;
			wptr_q <= 8'h00;
		end else if (REG_WR && st_q == spi_flash_pkg::HOST_IDLE) begin
			case (REG_ADDR)
				`HREG_CMD: begin
					op_q <= REG_WDATA[7:0];
					wptr_q <= 8'h00;
				end
				`HREG_ADDR: addr_q <= REG_WDATA[23:0];
				`HREG_LEN: begin
					len_q <= REG_WDATA[8:0];
					wptr_q <= 8'h00;
				end
				`HREG_DATA: wptr_q <= wptr_q + 8'h01;
				default: ;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (REG_WR && REG_ADDR == `HREG_DATA &&
				st_q == spi_flash_pkg::HOST_IDLE) begin
			data_buf[wptr_q] <= REG_WDATA[7:0];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			so_sync_q <= 2'h0;
		end else begin
			so_sync_q <= {so_sync_q[0], LINK.so};
		end
	end

	// frame sequencer; chip select rises only after a whole byte
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_q <= spi_flash_pkg::HOST_IDLE;
			cs_q <= 1'b1;
			sclk_q <= 1'b0;
			si_q <= 1'b0;
			div_q <= 4'h0;
			bit_q <= 16'h0000;
			total_q <= 16'h0000;
			rx_q <= 8'h00;
		end else begin
			case (st_q)
				spi_flash_pkg::HOST_IDLE: begin
					if (start) begin
						cs_q <= 1'b0;
						bit_q <= 16'h0000;
						div_q <= 4'h0;
						total_q <= hdr_bits(REG_WDATA[7:0]) + {4'h0, len_q, 3'h0};
						st_q <= spi_flash_pkg::HOST_LOW;
					end
				end
				spi_flash_pkg::HOST_LOW: begin
					si_q <= cur_bit;
					div_q <= half_done ? 4'h0 : div_q + 4'h1;
					if (half_done) begin
						sclk_q <= 1'b1;
						st_q <= spi_flash_pkg::HOST_HIGH;
					end
				end
				spi_flash_pkg::HOST_HIGH: begin
					div_q <= half_done ? 4'h0 : div_q + 4'h1;
					if (half_done) begin
						rx_q <= {rx_q[6:0], so_sync_q[1]};
						sclk_q <= 1'b0;
						if (bit_q == total_q - 16'h0001) begin
							st_q <= spi_flash_pkg::HOST_TAIL;
						end else begin
							bit_q <= bit_q + 16'h0001;
							st_q <= spi_flash_pkg::HOST_LOW;
						end
					end
				end
				spi_flash_pkg::HOST_TAIL: begin
					div_q <= half_done ? 4'h0 : div_q + 4'h1;
					if (half_done) begin
						cs_q <= 1'b1;
						st_q <= spi_flash_pkg::HOST_REST;
					end
				end
				spi_flash_pkg::HOST_REST: begin
					div_q <= half_done ? 4'h0 : div_q + 4'h1;
					if (half_done) st_q <= spi_flash_pkg::HOST_IDLE;
				end
				default: st_q <= spi_flash_pkg::HOST_IDLE;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= 32'h00000000;
			if (REG_RD) begin
				case (REG_ADDR)
					`HREG_ADDR: rdata_q <= {8'h00, addr_q};
					`HREG_LEN: rdata_q <= {23'h000000, len_q};
					`HREG_STAT: begin
						rdata_q[7:0] <= rx_q;
						rdata_q[`HSTAT_BUSY_BIT] <= (st_q != spi_flash_pkg::HOST_IDLE);
					end
					default: rdata_q <= 32'h00000000;
				endcase
			end
		end
	end

	assign LINK.cs_n = cs_q;
	assign LINK.sclk = sclk_q;
	assign LINK.si = si_q;
	assign REG_RDATA = rdata_q;
endmodule : flash_host

/* File: tb/flash_link_sva.sv */
/*
 Checker of the serial link between host and device, and device flags.
 Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/100ps
module flash_link_sva (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic si,
	input wire logic so,
	input wire logic WRITE_IN_PROGRESS_FLAG,
	input wire logic WRITE_ENABLE_LATCH,
	input wire logic RESET_BUSY
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	chk_sclk_idle_low: assert property (cs_n |-> !sclk)
		else $error("serial clock high while deselected");
	chk_sclk_high_len: assert property (
		$rose(sclk) |-> sclk[*4] ##1 !sclk)
		else $error("serial clock high phase not four cycles");
	chk_sclk_low_len: assert property (
		$fell(sclk) |-> !sclk[*4] ##[1:2] (sclk || cs_n))
		else $error("select not raised on a bit boundary");
	chk_si_held_high: assert property (
		sclk && $past(sclk) |-> $stable(si))
		else $error("serial input moved while clock high");
	chk_cs_gap_len: assert property ($rose(cs_n) |-> cs_n[*4])
		else $error("select high gap too short");
	chk_so_idle_low: assert property (
		cs_n && $past(cs_n, 4) |-> !so)
		else $error("serial output driven while deselected");
	chk_reset_quiet: assert property (
		RESET_BUSY && $past(RESET_BUSY) |-> !WRITE_IN_PROGRESS_FLAG && !WRITE_ENABLE_LATCH)
		else $error("activity during reset interval");
	chk_wel_clear: assert property ($rose(WRITE_IN_PROGRESS_FLAG) |-> !WRITE_ENABLE_LATCH)
		else $error("write enable kept at cycle start");
	chk_wip_start: assert property (
		$rose(WRITE_IN_PROGRESS_FLAG) |-> cs_n ##0 WRITE_IN_PROGRESS_FLAG[*8])
		else $error("progress flag started in frame or too short");
	chk_reset_start: assert property (
		$rose(RESET_BUSY) |-> cs_n ##1 RESET_BUSY[*8])
		else $error("reset interval started in frame or too short");
endmodule : flash_link_sva

/* File: tb/spi_flash_secreg_program_reset_tb.sv */
/*
 Bench joining flash host and flash device over the link.
 Assumes the register port and link timing of the designer's note.
*/
`timescale 1ns/100ps
`include "spi_flash_regs.svh"
module spi_flash_secreg_program_reset_tb;
	localparam int PROG = 300;
	localparam int ERASE = 800;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] ra = 4'h0;
	logic [31:0] wd = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic sec_lock = 1'b0;
	logic [2:0] area_lock = 3'h0;
	logic [4:0] bprot = 5'h0;
	logic [9:0] sec_addr = 10'h0;
	logic [7:0] sec_data;
	logic write_in_progress_flag, write_enable_latch, rbusy, mem_en;
	logic [23:0] mem_addr;
	logic [7:0] mem_data;
	logic [7:0] tx[$];
	logic [31:0] wq[$];
	int errors = 0;
	int n_compared = 0;
	spi_link_if link();
	flash_host flash_host_inst (.SYS_CLK(sys_clk), .RST_B(rst_b),
		.LINK(link), .REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(rdata));
	flash_device #(.ERASE_CYCLES(ERASE), .PROG_CYCLES(PROG))
		flash_device_inst (.SYS_CLK(sys_clk), .RST_B(rst_b), .LINK(link),
		.SEC_LOCK(sec_lock), .AREA_LOCK(area_lock), .BLOCK_PROT(bprot),
		.SEC_RD_ADDR(sec_addr), .SEC_RD_DATA(sec_data), .WRITE_IN_PROGRESS_FLAG(write_in_progress_flag),
		.WRITE_ENABLE_LATCH(write_enable_latch), .RESET_BUSY(rbusy), .MEM_WR_EN(mem_en),
		.MEM_WR_ADDR(mem_addr), .MEM_WR_DATA(mem_data));
	flash_link_sva flash_link_sva_inst (.SYS_CLK(sys_clk), .RST_B(rst_b),
		.cs_n(link.cs_n), .sclk(link.sclk), .si(link.si), .so(link.so),
		.WRITE_IN_PROGRESS_FLAG(write_in_progress_flag), .WRITE_ENABLE_LATCH(write_enable_latch), .RESET_BUSY(rbusy));
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	// main array writes as seen at the byte port
	always @(posedge sys_clk) begin
		if (mem_en === 1'b1) wq.push_back({mem_addr, mem_data});
	end
	task automatic conclude;
		if (errors == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude
	task automatic hang;
		errors++;
		conclude();
	endtask : hang
	task automatic check(input string w, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
		end
	endtask : check
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		ra <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		ra <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : reg_rd
	// one framed command; waits for the host to go idle
	task automatic frame(input logic [7:0] op, input logic [23:0] a,
		input int n);
		logic [31:0] s;
		reg_wr(`HREG_ADDR, {8'h00, a});
		reg_wr(`HREG_LEN, 32'(n));
		foreach (tx[i]) reg_wr(`HREG_DATA, {24'h0, tx[i]});
		reg_wr(`HREG_CMD, {24'h0, op});
		tx.delete();
		s = 32'h100;
		for (int i = 0; i < 20000 && s[`HSTAT_BUSY_BIT]; i++)
			reg_rd(`HREG_STAT, s);
		if (s[`HSTAT_BUSY_BIT] !== 1'b0) hang();
		repeat (4) @(posedge sys_clk);
	endtask : frame
	task automatic we;
		frame(`OP_WRITE_ENABLE, 24'h0, 0);
	endtask : we
	task automatic status(input logic [7:0] e, input string w);
		logic [31:0] s;
		frame(`OP_READ_STATUS, 24'h0, 1);
		reg_rd(`HREG_STAT, s);
		check(w, {24'h0, e}, s);
	endtask : status
	// flag is up now and falls within its documented interval
	task automatic hold_len(input bit rst, input int cyc);
		int c;
		c = 0;
		check("flag_up", 1, 32'(rst ? rbusy : write_in_progress_flag));
		while ((rst ? rbusy : write_in_progress_flag) === 1'b1 && c <= cyc) begin
			@(posedge sys_clk);
			c++;
		end
		check("flag_len", 1, 32'(c > cyc / 2 && c <= cyc));
	endtask : hold_len
	task automatic sec_rd(input logic [9:0] i, input logic [7:0] e);
		@(posedge sys_clk);
		sec_addr <= i;
		@(posedge sys_clk);
		@(posedge sys_clk);
		#1 check("sec_byte", {24'h0, e}, {24'h0, sec_data});
	endtask : sec_rd
	task automatic t_page;
		we();
		tx = '{8'hA1, 8'hB2, 8'hC3};
		frame(`OP_PAGE_PROGRAM, 24'h0012FE, 3);
		hold_len(0, PROG);
		check("wr_count", 3, 32'(wq.size()));
		check("wr0", 32'h001200C3, wq[0]);
		check("wr1", 32'h0012FEA1, wq[1]);
		check("wr2", 32'h0012FFB2, wq[2]);
		status(8'h00, "wel_after_prog");
		wq.delete();
		for (int k = 0; k < 2; k++) begin
			bprot <= 5'(k);
			if (k == 1) we();
			tx = '{8'h5A};
			frame(`OP_PAGE_PROGRAM, 24'h000100, 1);
			check("refused_wip", 0, 32'(write_in_progress_flag));
			check("refused_wr", 0, 32'(wq.size()));
		end
		bprot <= 5'h0;
	endtask : t_page
	task automatic t_erase;
		sec_lock <= 1'b1;
		we();
		frame(`OP_SEC_ERASE, 24'h0, 0);
		check("lock_wip", 0, 32'(write_in_progress_flag));
		sec_lock <= 1'b0;
		frame(`OP_SEC_ERASE, 24'h0, 1);
		check("long_wip", 0, 32'(write_in_progress_flag));
		frame(`OP_SEC_ERASE, 24'h0, 0);
		status(8'h01, "busy_status");
		we();
		hold_len(0, ERASE);
		status(8'h00, "we_ignored");
		sec_rd(10'h000, 8'hFF);
		sec_rd(10'h2FF, 8'hFF);
		frame(`OP_SEC_ERASE, 24'h0, 0);
		check("no_we_wip", 0, 32'(write_in_progress_flag));
	endtask : t_erase
	task automatic t_secprog;
		we();
		tx = '{8'hAA, 8'h55};
		frame(`OP_SEC_PROGRAM, 24'h002010, 2);
		hold_len(0, PROG);
		sec_rd(10'h110, 8'hAA);
		sec_rd(10'h111, 8'h55);
		sec_rd(10'h010, 8'hFF);
		area_lock <= 3'h4;
		we();
		tx = '{8'h00};
		frame(`OP_SEC_PROGRAM, 24'h003000, 1);
		check("alock_wip", 0, 32'(write_in_progress_flag));
		sec_rd(10'h200, 8'hFF);
		area_lock <= 3'h0;
	endtask : t_secprog
	// idle device before the pair, write enable still set
	task automatic t_reset;
		frame(`OP_RESET_ENABLE, 24'h0, 0);
		status(8'h02, "wel_armed");
		frame(`OP_RESET, 24'h0, 0);
		check("no_reset", 0, 32'(rbusy));
		frame(`OP_RESET_ENABLE, 24'h0, 0);
		frame(`OP_RESET, 24'h0, 0);
		we();
		hold_len(1, 1500);
		status(8'h00, "wel_cleared");
	endtask : t_reset
	task automatic t_params;
		logic [31:0] s;
		frame(`OP_READ_PARAMS, 24'h0, 1);
		reg_rd(`HREG_STAT, s);
		check("param_byte", 32'h000000FF, s);
	endtask : t_params
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_page();
		t_erase();
		t_secprog();
		t_reset();
		t_params();
		conclude();
	end
endmodule : spi_flash_secreg_program_reset_tb
